// File: shared/syc_defines.vh
// Register offsets, field positions and reset values of the system control group
`ifndef SYC_DEFINES_VH
`define SYC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SYC_OFS_VECTOR_BASE      16'hed08
`define SYC_OFS_INT_RESET_CTRL   16'hed0c
`define SYC_OFS_SLEEP_CONTROL    16'hed10

// ----------------------------------------
// Vector base fields
// ----------------------------------------
`define SYC_TBL_MSB              31
`define SYC_TBL_LSB              8
`define SYC_TBL_RESET            24'h000000

// ----------------------------------------
// Interrupt and reset control fields
// ----------------------------------------
`define SYC_KEY_MSB              31
`define SYC_KEY_LSB              16
`define SYC_UNLOCK_KEY           16'h05fa
`define SYC_KEY_READ             16'h0000
`define SYC_BYTE_ORDER_BIT       15
`define SYC_BYTE_ORDER_VAL       1'h0
`define SYC_RESET_REQ_BIT        2
`define SYC_CLR_ACTIVE_BIT       1

// ----------------------------------------
// Sleep control fields
// ----------------------------------------
`define SYC_SEND_EVT_PEND_BIT    4
`define SYC_DEEP_SLEEP_BIT       2
`define SYC_SLEEP_ON_EXIT_BIT    1
`define SYC_SLEEP_CTRL_RESET     1'h0

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define SYC_RESP_OKAY            2'h0
`define SYC_RESP_SLVERR          2'h2

`endif

// File: design/syc_top.v
// System control register group with AXI4-Lite slave, reset request and sleep logic
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "syc_defines.vh"

// How it works
// - Vector base holds read-write table base in bits 31:8, resets zero, low byte reserved.
// - Interrupt/reset control writes ignored unless upper halfword holds the unlock key.
// - Bit 15 of interrupt/reset control is read-only and reads 0, little-endian.
// - Keyed write of bit 2 raises the reset request toward the system.
// - A reset caused by the request clears the core-halt control bit.
// - Clear-active bit self-clears and is only settable from debug while halted.
// - Clear-active makes the core drop active exceptions, enter Thread, status 0.
// - Send-event-on-pending lets disabled interrupts also wake the core when set.
// - Pending event wakes a waiting core, otherwise is latched for next wait.
// - Send-event instruction or external event input also ends a wait.
// - Sleep control bit 2 selects ordinary sleep or deep sleep.
// - Sleep-on-exit makes core sleep on return from Handler to Thread.
// - Sleep control bits read-write, reset 0, other bits reserved.
module syc_top #(
	parameter ADDR_W = 16                     // Bus address width
) (
	input  wire              CLK_SYS_IN,      // Core clock, 25 MHz
	input  wire              RST_B_IN,        // Async reset, active low
	// AXI4-Lite slave
	input  wire [ADDR_W-1:0] AWADDR_IN,       // Write address
	input  wire              AWVALID_IN,      // Write address valid
	output reg               AWREADY_OUT,     // Write address ready
	input  wire [31:0]       WDATA_IN,        // Write data
	input  wire [3:0]        WSTRB_IN,        // Write byte enables
	input  wire              WVALID_IN,       // Write data valid
	output reg               WREADY_OUT,      // Write data ready
	output reg  [1:0]        BRESP_OUT,       // Write response
	output reg               BVALID_OUT,      // Write response valid
	input  wire              BREADY_IN,       // Write response ready
	input  wire [ADDR_W-1:0] ARADDR_IN,       // Read address
	input  wire              ARVALID_IN,      // Read address valid
	output reg               ARREADY_OUT,     // Read address ready
	output reg  [31:0]       RDATA_OUT,       // Read data
	output reg  [1:0]        RRESP_OUT,       // Read response
	output reg               RVALID_OUT,      // Read data valid
	input  wire              RREADY_IN,       // Read data ready
	// Core and debug side
	input  wire              DBG_ACCESS_IN,   // Write comes from debug access port
	input  wire              CORE_HALTED_IN,  // Core halted by debugger
	input  wire              IRQ_PEND_EN_IN,  // Enabled interrupt became pending
	input  wire              IRQ_PEND_DIS_IN, // Disabled interrupt became pending
	input  wire              SEND_EVENT_IN,   // Core executed send-event
	input  wire              WAIT_EVENT_IN,   // Core executed wait-for-event
	input  wire              EXIT_THREAD_IN,  // Return from Handler to Thread
	input  wire              EXT_EVENT_IN,    // External event pin, async
	input  wire              SYS_RST_ACK_IN,  // System reset carried out
	output reg  [31:0]       TABLE_BASE_OUT,  // Vector table base address
	output reg               RESET_REQ_OUT,   // System reset request
	output reg               HALT_CLEAR_OUT,  // Clear core-halt bit, pulse
	output reg               CLR_ACTIVE_OUT,  // Clear active exceptions, pulse
	output reg               WAKE_OUT,        // Wake core, pulse
	output reg               SLEEP_OUT,       // Ordinary sleep indication
	output reg               DEEP_SLEEP_OUT   // Deep sleep indication
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg  [23:0]       table_base_field_r;
	reg               reset_request_r;
	reg               send_event_on_pending_r;
	reg               deep_sleep_select_r;
	reg               sleep_on_exit_a_r;
	reg               event_latch_r;
	reg               event_latch_nxt;
	reg               sleeping_r;
	reg               sleeping_nxt;
	reg               wait_mode_r;
	reg               wait_mode_nxt;
	reg               wake_nxt;
	reg               ext_meta_r;
	reg               ext_sync_r;
	reg               ext_prev_r;

	// Write channel holding state
	reg               aw_held_r;
	reg               w_held_r;
	reg  [ADDR_W-1:0] aw_addr_r;
	reg  [31:0]       w_data_r;
	reg  [3:0]        w_strb_r;
	reg               w_dbg_r;

	wire              wr_go;
	wire              wr_vec;
	wire              wr_irc;
	wire              wr_slp;
	wire              key_ok;
	wire              clr_allowed;
	wire              ext_rise;
	wire              any_event;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Commit once both halves are held and the last answer is gone
	assign wr_go  = aw_held_r & w_held_r & ~BVALID_OUT;
	assign wr_vec = wr_go & (aw_addr_r == `SYC_OFS_VECTOR_BASE);
	assign wr_irc = wr_go & (aw_addr_r == `SYC_OFS_INT_RESET_CTRL);
	assign wr_slp = wr_go & (aw_addr_r == `SYC_OFS_SLEEP_CONTROL);

	// Key must be written whole in the upper halfword
	assign key_ok = wr_irc & (w_strb_r[3:2] == 2'h3) & w_strb_r[0] &
		(w_data_r[`SYC_KEY_MSB:`SYC_KEY_LSB] == `SYC_UNLOCK_KEY);

	// Clear-active only from debug port while halted
	assign clr_allowed = key_ok & w_dbg_r & CORE_HALTED_IN &
		w_data_r[`SYC_CLR_ACTIVE_BIT];

	// ----------------------------------------
	// Write address and data capture
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			AWREADY_OUT <= 1'b0;
			WREADY_OUT  <= 1'b0;
			aw_held_r   <= 1'b0;
			w_held_r    <= 1'b0;
			aw_addr_r   <= {ADDR_W{1'b0}};
			w_data_r    <= 32'h00000000;
			w_strb_r    <= 4'h0;
			w_dbg_r     <= 1'b0;
		end else begin
			// Ready pulses one cycle once valid seen
			AWREADY_OUT <= AWVALID_IN & ~AWREADY_OUT & ~aw_held_r & ~BVALID_OUT;
			WREADY_OUT  <= WVALID_IN & ~WREADY_OUT & ~w_held_r & ~BVALID_OUT;
			if (AWVALID_IN & AWREADY_OUT) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= AWADDR_IN;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			if (WVALID_IN & WREADY_OUT) begin
				w_held_r <= 1'b1;
				w_data_r <= WDATA_IN;
				w_strb_r <= WSTRB_IN;
				w_dbg_r  <= DBG_ACCESS_IN;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			BVALID_OUT <= 1'b0;
			BRESP_OUT  <= `SYC_RESP_OKAY;
		end else if (wr_go) begin
			// Unmapped offsets answer SLVERR and change nothing
			BVALID_OUT <= 1'b1;
			BRESP_OUT  <= (wr_vec | wr_irc | wr_slp) ? `SYC_RESP_OKAY : `SYC_RESP_SLVERR;
		end else if (BREADY_IN) begin
			BVALID_OUT <= 1'b0;
		end
	end

	// ----------------------------------------
	// Vector base and sleep control registers
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			table_base_field_r      <= `SYC_TBL_RESET;
			send_event_on_pending_r <= `SYC_SLEEP_CTRL_RESET;
			deep_sleep_select_r     <= `SYC_SLEEP_CTRL_RESET;
			sleep_on_exit_a_r       <= `SYC_SLEEP_CTRL_RESET;
		end else begin
			// Byte lanes honoured, low byte reserved
			if (wr_vec) begin
				if (w_strb_r[1])
					table_base_field_r[7:0] <= w_data_r[15:8];
				if (w_strb_r[2])
					table_base_field_r[15:8] <= w_data_r[23:16];
				if (w_strb_r[3])
					table_base_field_r[23:16] <= w_data_r[31:24];
			end
			if (wr_slp & w_strb_r[0]) begin
				send_event_on_pending_r <= w_data_r[`SYC_SEND_EVT_PEND_BIT];
				deep_sleep_select_r     <= w_data_r[`SYC_DEEP_SLEEP_BIT];
				sleep_on_exit_a_r       <= w_data_r[`SYC_SLEEP_ON_EXIT_BIT];
			end
		end
	end

	// ----------------------------------------
	// Reset request and clear-active pulses
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			reset_request_r <= 1'b0;
			RESET_REQ_OUT   <= 1'b0;
			HALT_CLEAR_OUT  <= 1'b0;
			CLR_ACTIVE_OUT  <= 1'b0;
		end else begin
			// Held until the reset controller acts, new request wins
			if (key_ok & w_data_r[`SYC_RESET_REQ_BIT])
				reset_request_r <= 1'b1;
			else if (SYS_RST_ACK_IN)
				reset_request_r <= 1'b0;
			RESET_REQ_OUT  <= (key_ok & w_data_r[`SYC_RESET_REQ_BIT]) |
				(reset_request_r & ~SYS_RST_ACK_IN);
			// Reset from the request drops the halt bit
			HALT_CLEAR_OUT <= reset_request_r & SYS_RST_ACK_IN;
			// Self-clearing: one pulse to the core
			CLR_ACTIVE_OUT <= clr_allowed;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT  <= 1'b0;
			RDATA_OUT   <= 32'h00000000;
			RRESP_OUT   <= `SYC_RESP_OKAY;
		end else begin
			// Ready pulses one cycle, none while read data still waits
			ARREADY_OUT <= ARVALID_IN & ~ARREADY_OUT & ~RVALID_OUT;
			if (ARVALID_IN & ARREADY_OUT) begin
				RVALID_OUT <= 1'b1;
				RRESP_OUT  <= `SYC_RESP_OKAY;
				// Cleared first so reserved bits read zero
				RDATA_OUT  <= 32'h00000000;
				case (ARADDR_IN)
				`SYC_OFS_VECTOR_BASE: begin
					RDATA_OUT <= {table_base_field_r, 8'h00};
				end
				`SYC_OFS_INT_RESET_CTRL: begin
					// Key field reads 0x0000, clear-active reads 0
					RDATA_OUT[`SYC_KEY_MSB:`SYC_KEY_LSB] <= `SYC_KEY_READ;
					RDATA_OUT[`SYC_BYTE_ORDER_BIT] <= `SYC_BYTE_ORDER_VAL;
					RDATA_OUT[`SYC_RESET_REQ_BIT]  <= reset_request_r;
				end
				`SYC_OFS_SLEEP_CONTROL: begin
					RDATA_OUT[`SYC_SEND_EVT_PEND_BIT] <= send_event_on_pending_r;
					RDATA_OUT[`SYC_DEEP_SLEEP_BIT]    <= deep_sleep_select_r;
					RDATA_OUT[`SYC_SLEEP_ON_EXIT_BIT] <= sleep_on_exit_a_r;
				end
				default: begin
					RRESP_OUT <= `SYC_RESP_SLVERR;
				end
				endcase
			end else if (RREADY_IN) begin
				RVALID_OUT <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// External event synchroniser
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			// Two stages before anything reads the pin
			ext_meta_r <= EXT_EVENT_IN;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	// Rising edge only, a held pin gives one event
	assign ext_rise = ext_sync_r & ~ext_prev_r;

	// Events able to end a wait
	assign any_event = IRQ_PEND_EN_IN | SEND_EVENT_IN | ext_rise |
		(IRQ_PEND_DIS_IN & send_event_on_pending_r);

	// ----------------------------------------
	// Sleep and event latch next state
	// ----------------------------------------
	always @* begin
		event_latch_nxt = event_latch_r;
		sleeping_nxt    = sleeping_r;
		wait_mode_nxt   = wait_mode_r;
		wake_nxt        = 1'b0;
		if (sleeping_r) begin
			// Wait sleep ends on any event, exit sleep on interrupt
			if (wait_mode_r ? any_event : (IRQ_PEND_EN_IN |
				(IRQ_PEND_DIS_IN & send_event_on_pending_r))) begin
				sleeping_nxt = 1'b0;
				wake_nxt     = 1'b1;
			end
			// Exit sleep waits for no event, so events are kept for the next wait
			if (!wait_mode_r & any_event)
				event_latch_nxt = 1'b1;
		end else if (WAIT_EVENT_IN) begin
			if (event_latch_r | any_event) begin
				// Latched event satisfies it, fresh one kept
				event_latch_nxt = event_latch_r & any_event;
				wake_nxt        = 1'b1;
			end else begin
				sleeping_nxt  = 1'b1;
				wait_mode_nxt = 1'b1;
			end
		end else if (EXIT_THREAD_IN & sleep_on_exit_a_r) begin
			sleeping_nxt  = 1'b1;
			wait_mode_nxt = 1'b0;
			if (any_event)
				event_latch_nxt = 1'b1;
		end else if (any_event) begin
			event_latch_nxt = 1'b1;
		end
	end

	// ----------------------------------------
	// Sleep state and outputs
	// ----------------------------------------
	always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			event_latch_r  <= 1'b0;
			sleeping_r     <= 1'b0;
			wait_mode_r    <= 1'b0;
			WAKE_OUT       <= 1'b0;
			SLEEP_OUT      <= 1'b0;
			DEEP_SLEEP_OUT <= 1'b0;
			TABLE_BASE_OUT <= 32'h00000000;
		end else begin
			event_latch_r  <= event_latch_nxt;
			sleeping_r     <= sleeping_nxt;
			wait_mode_r    <= wait_mode_nxt;
			WAKE_OUT       <= wake_nxt;
			// Depth chosen by deep-sleep select
			SLEEP_OUT      <= sleeping_nxt & ~deep_sleep_select_r;
			DEEP_SLEEP_OUT <= sleeping_nxt & deep_sleep_select_r;
			TABLE_BASE_OUT <= {table_base_field_r, 8'h00};
		end
	end

endmodule // syc_top

// File: test/syc_checker.sv
// Checker of bus answers, reset request and sleep outputs
`timescale 1ns/10ps
module syc_checker (
	input logic        CLK_SYS_IN,     // Core clock
	input logic        RST_B_IN,       // Reset, active low
	input logic        ARVALID_IN,     // Read address valid
	input logic        RVALID_OUT,     // Read data valid
	input logic        AWVALID_IN,     // Write address valid
	input logic        WVALID_IN,      // Write data valid
	input logic        BVALID_OUT,     // Write response valid
	input logic        SYS_RST_ACK_IN, // Reset carried out
	input logic        RESET_REQ_OUT,  // Reset request
	input logic        HALT_CLEAR_OUT, // Halt clear pulse
	input logic        CLR_ACTIVE_OUT, // Clear active pulse
	input logic        WAKE_OUT,       // Wake pulse
	input logic        SLEEP_OUT,      // Sleep level
	input logic        DEEP_SLEEP_OUT, // Deep sleep level
	input logic [31:0] TABLE_BASE_OUT  // Table base
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_read_answer: assert property ($rose(ARVALID_IN) |-> ##2 RVALID_OUT)
		else $error("read answer not two cycles after request");
	chk_write_answer: assert property ($rose(AWVALID_IN) && WVALID_IN |-> ##3 BVALID_OUT)
		else $error("write answer not three cycles after request");
	chk_req_hold: assert property (RESET_REQ_OUT && !SYS_RST_ACK_IN |=> RESET_REQ_OUT)
		else $error("reset request dropped before answer");
	chk_halt_clear: assert property (RESET_REQ_OUT && SYS_RST_ACK_IN |=> HALT_CLEAR_OUT)
		else $error("halt clear missing after reset");
	chk_sleep_excl: assert property (!(SLEEP_OUT && DEEP_SLEEP_OUT))
		else $error("both sleep outputs high");
	chk_table_low: assert property (TABLE_BASE_OUT[7:0] == 8'h00)
		else $error("table base low byte not zero");
	chk_wake_awake: assert property (WAKE_OUT |-> !SLEEP_OUT && !DEEP_SLEEP_OUT)
		else $error("sleep output high during wake");
	chk_clr_single: assert property (CLR_ACTIVE_OUT |=> !CLR_ACTIVE_OUT)
		else $error("clear active not self clearing");
	cov_reset_req: cover property ($rose(RESET_REQ_OUT));
	cov_clr_active: cover property (CLR_ACTIVE_OUT);
	cov_deep_sleep: cover property ($rose(DEEP_SLEEP_OUT));
endmodule // syc_checker

// File: test/syc_rst_model.sv
// Reset controller model answering reset requests after a set delay
`timescale 1ns/10ps
module syc_rst_model (
	input  wire       clk_in,   // Core clock
	input  wire       rst_b_in, // Reset, active low
	input  wire       req_in,   // Reset request
	input  wire [7:0] dly_in,   // Answer delay in cycles
	output reg        ack_out   // Reset done, pulse
);
	reg [7:0] cnt_r;
	// Count while requested, then answer once
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_r <= 8'h00;
			ack_out <= 1'b0;
		end else if (req_in && !ack_out && cnt_r >= dly_in) begin
			cnt_r <= 8'h00;
			ack_out <= 1'b1;
		end else begin
			cnt_r <= req_in ? cnt_r + 8'h01 : 8'h00;
			ack_out <= 1'b0;
		end
	end
endmodule // syc_rst_model

// File: test/syc_top_tb.sv
// Self-checking bench of the system control register group
`timescale 1ns/10ps
`include "syc_defines.vh"
module syc_top_tb;
	localparam [15:0] vb = `SYC_OFS_VECTOR_BASE;
	localparam [15:0] ic = `SYC_OFS_INT_RESET_CTRL;
	localparam [15:0] sc = `SYC_OFS_SLEEP_CONTROL;
	logic        clk = 0, rst_b = 0, dbg = 0, halted = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [15:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, r;
	logic [3:0]  wstrb = 0;
	logic [5:0]  ev = 0;
	logic [7:0]  dly = 8'h01;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata, tbase;
	wire         awready, wready, bvalid, arready, rvalid, ack, req, clr, slp, dslp;
	wire         halt, wake;
	int          mismatches = 0, comparisons = 0, cyc = 0, nclr = 0, nhalt = 0, nwake = 0;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	always #20 clk = ~clk;
	syc_top syc_top_i (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .AWADDR_IN(awaddr),
		.AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
		.WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
		.BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
		.RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
		.DBG_ACCESS_IN(dbg), .CORE_HALTED_IN(halted), .IRQ_PEND_EN_IN(ev[0]),
		.IRQ_PEND_DIS_IN(ev[1]), .SEND_EVENT_IN(ev[2]), .WAIT_EVENT_IN(ev[3]),
		.EXIT_THREAD_IN(ev[4]), .EXT_EVENT_IN(ev[5]), .SYS_RST_ACK_IN(ack),
		.TABLE_BASE_OUT(tbase), .RESET_REQ_OUT(req), .HALT_CLEAR_OUT(halt),
		.CLR_ACTIVE_OUT(clr), .WAKE_OUT(wake), .SLEEP_OUT(slp), .DEEP_SLEEP_OUT(dslp));
	syc_rst_model syc_rst_model_i (.clk_in(clk), .rst_b_in(rst_b), .req_in(req),
		.dly_in(dly), .ack_out(ack));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bus write: note expected response, hold each channel until taken
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e = 0);
		@(posedge clk);
		bq.push_back(e);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end while (!bvalid);
		bready <= 0;
	endtask
	// Bus read: note expected response and data
	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e = 0);
		@(posedge clk);
		rq.push_back({e, d});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			arvalid <= arvalid & ~arready;
		end while (!rvalid);
		rready <= 0;
	endtask
	// One-cycle pulse on core side inputs, then settle past the sync stages
	task automatic pulse(input logic [5:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 0;
		repeat (5) @(posedge clk);
	endtask
	// Watcher: compares answers against the oldest notes, cuts hangs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (clr)
			nclr <= nclr + 1;
		if (halt)
			nhalt <= nhalt + 1;
		if (wake)
			nwake <= nwake + 1;
		if (bvalid && bready)
			chk(bresp, bq.pop_front());
		if (rvalid && rready)
			chk({rresp, rdata}, rq.pop_front());
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(34));
		repeat (8) @(posedge clk);
		rst_b <= 1;
		rd(vb, 0);
		rd(ic, 0);
		rd(sc, 0);
		rd(16'hed14, 0, `SYC_RESP_SLVERR);
		wr(16'hed14, 32'h1, `SYC_RESP_SLVERR);
		r = $urandom();
		wr(vb, r);
		repeat (2) @(posedge clk);
		chk(tbase, {r[31:8], 8'h00});
		rd(vb, {r[31:8], 8'h00});
		$display("test registers done");
		wr(ic, 32'h05fb0004);
		repeat (3) @(posedge clk);
		chk(req, 0);
		wr(ic, 32'h05fa0004);
		repeat (4) @(posedge clk);
		chk(req, 0);
		chk(nhalt, 1);
		dly <= 8'h14;
		wr(ic, 32'h05fa0004);
		@(posedge clk);
		chk(req, 1);
		rd(ic, 32'h4);
		repeat (30) @(posedge clk);
		chk(req, 0);
		chk(nhalt, 2);
		$display("test reset request done");
		wr(ic, 32'h05fa0002);
		repeat (3) @(posedge clk);
		chk(nclr, 0);
		dbg <= 1;
		halted <= 1;
		wr(ic, 32'h05fa0002);
		repeat (3) @(posedge clk);
		chk(nclr, 1);
		rd(ic, 0);
		$display("test clear active done");
		wr(sc, 32'hffffffff);
		rd(sc, 32'h16);
		wr(sc, 32'h4);
		pulse(6'h08);
		chk({dslp, slp}, 2'b10);
		pulse(6'h02);
		chk({dslp, slp}, 2'b10);
		pulse(6'h01);
		chk({dslp, slp}, 2'b00);
		chk(nwake, 1);
		wr(sc, 32'h10);
		pulse(6'h08);
		chk({dslp, slp}, 2'b01);
		pulse(6'h02);
		chk({dslp, slp}, 2'b00);
		pulse(6'h04);
		pulse(6'h08);
		chk({dslp, slp}, 2'b00);
		chk(nwake, 3);
		pulse(6'h08);
		pulse(6'h20);
		chk({dslp, slp}, 2'b00);
		wr(sc, 32'h2);
		pulse(6'h10);
		chk({dslp, slp}, 2'b01);
		pulse(6'h01);
		chk({dslp, slp}, 2'b00);
		chk(nwake, 5);
		$display("test sleep done");
		results();
	end
endmodule // syc_top_tb
bind syc_top syc_checker syc_checker_i (.*);
